// ===== rtl/rx_status_calendar_flow_ctrl.sv
// receive flow-control status generator with calendar and status tables
`timescale 1ns/1ps
`default_nettype none
`include "rx_status_params.svh"
module rx_status_calendar_flow_ctrl
	import rx_status_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_calendar_write_strobe_n,
	input wire logic [8:0] i_calendar_index,
	input wire logic [7:0] i_calendar_write_channel,
	output logic [7:0] o_calendar_read_channel,
	input wire logic [31:0] i_status_write_word,
	input wire logic [3:0] i_status_bank_select,
	input wire logic i_status_write_strobe_n,
	input wire logic [15:0] i_status_channel_mask,
	input wire logic i_parity_error_inject_req,
	input wire logic i_dip4_error,
	input wire logic i_dip4_ok,
	input wire logic i_train_pattern_done,
	input wire logic i_train_pattern_bad,
	input wire logic [8:0] i_fifo_free_count,
	output logic o_status_link_clk,
	output logic [1:0] o_status_link_data,
	output logic o_rx_almost_full_n,
	output logic o_rx_out_of_frame
);

	logic [4:0] ctrl_ff;
	logic [7:0] frame_cfg_ff;
	logic [7:0] repeat_ff;
	logic [8:0] length_ff;
	logic [8:0] af_on_ff;
	logic [8:0] af_off_ff;
	logic [7:0] cal_mem [0:511];
	status_code_t stat_mem [0:255];
	logic [3:0] loss_cnt_ff;
	logic [3:0] acq_cnt_ff;
	logic sync_lost_ff;
	logic af_ff;
	logic oof_ff;
	logic [2:0] div_cnt_ff;
	logic link_clk_ff;
	link_state_e st_ff;
	logic [8:0] cal_pos_ff;
	logic [7:0] rep_ff;
	status_code_t dip_ff;
	logic inject_ff;
	logic [1:0] data_ff;
	logic [7:0] cal_rd_ff;
	logic apb_wr;
	logic [1:0] policy;
	logic [8:0] on_thr;
	logic [8:0] off_thr;
	logic [2:0] half;
	logic tick;
	logic upd;
	logic [7:0] cur_chan;
	status_code_t cur_val;

	// a zero count setting behaves as one
	function automatic logic [3:0] clamp_count(input logic [3:0] v);
		clamp_count = (v == 4'h0) ? 4'h1 : v;
	endfunction

	// keep a threshold inside lo..max
	function automatic logic [8:0] clamp_thr(input logic [8:0] v, input logic [8:0] lo);
		if (v < lo)
			clamp_thr = lo;
		else if (v > `AF_MAX)
			clamp_thr = `AF_MAX;
		else
			clamp_thr = v;
	endfunction

	// running parity: rotate then fold in the next status word
	function automatic status_code_t dip2_step(input status_code_t acc, input status_code_t w);
		dip2_step = {acc[0], acc[1]} ^ w;
	endfunction

	// only the five word offsets decode, anything else errors
	function automatic logic addr_hit(input logic [11:0] a);
		addr_hit = (a == `OFS_CTRL) || (a == `OFS_FRAME) || (a == `OFS_CAL) ||
			(a == `OFS_AF) || (a == `OFS_STATE);
	endfunction

	// zero wait state slave
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel & i_penable & ~addr_hit(i_paddr);
	assign apb_wr = i_psel & i_penable & i_pwrite & addr_hit(i_paddr);
	assign policy = ctrl_ff[`CTRL_POL_HI:`CTRL_POL_LO];
	assign on_thr = clamp_thr(af_on_ff, `AF_MIN);
	assign off_thr = clamp_thr(af_off_ff, on_thr);

	// configuration writes; calendar setup should only change while disabled
	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			ctrl_ff <= `CTRL_RESET;
			frame_cfg_ff <= `FRAME_RESET;
			repeat_ff <= 8'h00;
			length_ff <= 9'h000;
			af_on_ff <= `AF_ON_RESET;
			af_off_ff <= `AF_OFF_RESET;
		end
		else if (apb_wr)
		begin
			if (i_paddr == `OFS_CTRL)
				ctrl_ff <= i_pwdata[`CTRL_POL_HI:`CTRL_EN];
			else if (i_paddr == `OFS_FRAME)
				frame_cfg_ff <= i_pwdata[`FRM_ACQ_HI:`FRM_LOSS_LO];
			else if (i_paddr == `OFS_CAL)
			begin
				repeat_ff <= i_pwdata[`CAL_REP_HI:`CAL_REP_LO];
				length_ff <= i_pwdata[`CAL_LEN_HI:`CAL_LEN_LO];
			end
			else if (i_paddr == `OFS_AF)
			begin
				af_on_ff <= i_pwdata[`AF_ON_HI:`AF_ON_LO];
				af_off_ff <= i_pwdata[`AF_OFF_HI:`AF_OFF_LO];
			end
		end
	end

	// read data captured in the setup cycle so it stands through access
	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_prdata <= 32'h0000_0000;
		else if (i_psel && !i_penable)
		begin
			o_prdata <= 32'h0000_0000;
			if (i_paddr == `OFS_CTRL)
				o_prdata[`CTRL_POL_HI:`CTRL_EN] <= ctrl_ff;
			else if (i_paddr == `OFS_FRAME)
				o_prdata[`FRM_ACQ_HI:`FRM_LOSS_LO] <= frame_cfg_ff;
			else if (i_paddr == `OFS_CAL)
			begin
				o_prdata[`CAL_REP_HI:`CAL_REP_LO] <= repeat_ff;
				o_prdata[`CAL_LEN_HI:`CAL_LEN_LO] <= length_ff;
			end
			else if (i_paddr == `OFS_AF)
			begin
				o_prdata[`AF_ON_HI:`AF_ON_LO] <= af_on_ff;
				o_prdata[`AF_OFF_HI:`AF_OFF_LO] <= af_off_ff;
			end
			else if (i_paddr == `OFS_STATE)
				o_prdata[1:0] <= {af_ff, oof_ff};
		end
	end

	// calendar table port
	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			for (int k = 0; k < 512; k++)
				cal_mem[k] <= 8'h00;
			cal_rd_ff <= 8'h00;
		end
		else if (!i_calendar_write_strobe_n)
			cal_mem[i_calendar_index] <= i_calendar_write_channel;
		else
			cal_rd_ff <= cal_mem[i_calendar_index];
	end
	assign o_calendar_read_channel = cal_rd_ff;

	// status table: whole 2-bit entries change in one edge, never half
	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			for (int k = 0; k < 256; k++)
				stat_mem[k] <= 2'h0;
		end
		else if (!i_status_write_strobe_n)
		begin
			for (int k = 0; k < 16; k++)
				if (i_status_channel_mask[k])
					stat_mem[{i_status_bank_select, 4'(k)}] <= i_status_write_word[2*k +: 2];
		end
	end

	// frame loss and acquisition counters
	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			sync_lost_ff <= 1'b1;
			loss_cnt_ff <= 4'h0;
			acq_cnt_ff <= 4'h0;
		end
		else if (!ctrl_ff[`CTRL_EN])
		begin
			sync_lost_ff <= 1'b1;
			loss_cnt_ff <= 4'h0;
			acq_cnt_ff <= 4'h0;
		end
		else if (sync_lost_ff)
		begin
			if (i_train_pattern_bad)
				acq_cnt_ff <= 4'h0;
			else if (i_train_pattern_done)
			begin
				if ({1'b0, acq_cnt_ff} + 5'h01 >= {1'b0, clamp_count(frame_cfg_ff[`FRM_ACQ_HI:`FRM_ACQ_LO])})
				begin
					sync_lost_ff <= 1'b0;
					acq_cnt_ff <= 4'h0;
				end
				else
					acq_cnt_ff <= acq_cnt_ff + 4'h1;
			end
		end
		else if (i_dip4_error)
		begin
			if ({1'b0, loss_cnt_ff} + 5'h01 >= {1'b0, clamp_count(frame_cfg_ff[`FRM_LOSS_HI:`FRM_LOSS_LO])})
			begin
				sync_lost_ff <= 1'b1;
				loss_cnt_ff <= 4'h0;
			end
			else
				loss_cnt_ff <= loss_cnt_ff + 4'h1;
		end
		else if (i_dip4_ok)
			loss_cnt_ff <= 4'h0;
	end

	// almost-full with hysteresis, then the frame indication
	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			af_ff <= 1'b0;
			oof_ff <= 1'b1;
		end
		else
		begin
			if (i_fifo_free_count <= on_thr)
				af_ff <= 1'b1;
			else if (i_fifo_free_count >= off_thr)
				af_ff <= 1'b0;
			oof_ff <= !ctrl_ff[`CTRL_EN] || sync_lost_ff || (af_ff && policy == `POL_OOF);
		end
	end
	assign o_rx_almost_full_n = ~af_ff;
	assign o_rx_out_of_frame = oof_ff;

	// link clock divider; half period of 2 or 4 reference cycles
	assign half = ctrl_ff[`CTRL_DIV] ? `HALF_DIV8 : `HALF_DIV4;
	assign tick = (div_cnt_ff == half - 3'h1);
	assign upd = tick && (ctrl_ff[`CTRL_EDGE] ? link_clk_ff : !link_clk_ff);
	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			div_cnt_ff <= 3'h0;
			link_clk_ff <= 1'b0;
		end
		else if (tick)
		begin
			div_cnt_ff <= 3'h0;
			link_clk_ff <= ~link_clk_ff;
		end
		else
			div_cnt_ff <= div_cnt_ff + 3'h1;
	end
	assign o_status_link_clk = link_clk_ff;

	// channel value for the current calendar slot
	assign cur_chan = cal_mem[cal_pos_ff];
	assign cur_val = (af_ff && policy == `POL_SAT) ? `WORD_SATISFIED : stat_mem[cur_chan];

	// parity inject request waits for the next parity word; set beats clear
	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			inject_ff <= 1'b0;
		else if (i_parity_error_inject_req)
			inject_ff <= 1'b1;
		else if (upd && !oof_ff && st_ff == ST_DIP)
			inject_ff <= 1'b0;
	end

	// status channel sequencer, stepping once per link bit
	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			st_ff <= ST_OOF;
			cal_pos_ff <= 9'h000;
			rep_ff <= 8'h00;
			dip_ff <= 2'h0;
			data_ff <= `WORD_FRAME;
		end
		else if (upd)
		begin
			if (oof_ff)
			begin
				st_ff <= ST_OOF;
				data_ff <= `WORD_FRAME;
			end
			else
			begin
				case (st_ff)
					ST_OOF:
					begin
						data_ff <= `WORD_FRAME;
						st_ff <= ST_FRAME;
					end
					ST_FRAME:
					begin
						data_ff <= `WORD_FRAME;
						cal_pos_ff <= 9'h000;
						rep_ff <= 8'h00;
						dip_ff <= 2'h0;
						st_ff <= ST_STATUS;
					end
					ST_STATUS:
					begin
						data_ff <= cur_val;
						dip_ff <= dip2_step(dip_ff, cur_val);
						if (cal_pos_ff == length_ff)
						begin
							cal_pos_ff <= 9'h000;
							if (rep_ff == repeat_ff)
								st_ff <= ST_DIP;
							else
								rep_ff <= rep_ff + 8'h01;
						end
						else
							cal_pos_ff <= cal_pos_ff + 9'h001;
					end
					ST_DIP:
					begin
						data_ff <= inject_ff ? ~dip_ff : dip_ff;
						st_ff <= ST_FRAME;
					end
					default:
						st_ff <= ST_OOF;
				endcase
			end
		end
	end
	assign o_status_link_data = data_ff;

	// cycles since the last control write; a divide change needs time to settle
	logic [3:0] ctrl_age_ff;
	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			ctrl_age_ff <= 4'h0;
		else if (apb_wr && i_paddr == `OFS_CTRL)
			ctrl_age_ff <= 4'h0;
		else if (ctrl_age_ff != 4'hF)
			ctrl_age_ff <= ctrl_age_ff + 4'h1;
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	property p_cal_write;
		!i_calendar_write_strobe_n |=> cal_mem[$past(i_calendar_index)] == $past(i_calendar_write_channel);
	endproperty
	a_cal_write: assert property (p_cal_write) else $error("calendar write lost");

	property p_cal_read;
		i_calendar_write_strobe_n |=> o_calendar_read_channel == cal_mem[$past(i_calendar_index)];
	endproperty
	a_cal_read: assert property (p_cal_read) else $error("calendar read wrong");

	property p_stat_write;
		!i_status_write_strobe_n && i_status_channel_mask[0]
			|=> stat_mem[{$past(i_status_bank_select), 4'h0}] == $past(i_status_write_word[1:0]);
	endproperty
	a_stat_write: assert property (p_stat_write) else $error("status write lost");

	property p_stat_ignore;
		(i_status_write_strobe_n || !i_status_channel_mask[0]) && i_status_bank_select == 4'h0
			|=> $stable(stat_mem[0]);
	endproperty
	a_stat_ignore: assert property (p_stat_ignore) else $error("status changed without strobe");

	property p_oof_disabled;
		!ctrl_ff[`CTRL_EN] |=> oof_ff ##1 sync_lost_ff;
	endproperty
	a_oof_disabled: assert property (p_oof_disabled) else $error("in frame while disabled");

	property p_oof_word;
		oof_ff && upd |=> o_status_link_data == `WORD_FRAME && st_ff == ST_OOF;
	endproperty
	a_oof_word: assert property (p_oof_word) else $error("no framing word out of frame");

	property p_af_on;
		i_fifo_free_count <= on_thr |=> !o_rx_almost_full_n;
	endproperty
	a_af_on: assert property (p_af_on) else $error("almost-full not set");

	property p_af_off;
		i_fifo_free_count >= off_thr && i_fifo_free_count > on_thr |=> o_rx_almost_full_n;
	endproperty
	a_af_off: assert property (p_af_off) else $error("almost-full not cleared");

	// looks back five cycles, only once 15 cycles pass without a control write, so a divide change cannot trip it
	property p_clk_quarter;
		$rose(link_clk_ff) && !ctrl_ff[`CTRL_DIV] && ctrl_age_ff == 4'hF
			|-> !$past(link_clk_ff, 2) && $past(link_clk_ff, 3) && $past(link_clk_ff, 4)
			&& !$past(link_clk_ff, 5);
	endproperty
	a_clk_quarter: assert property (p_clk_quarter) else $error("link clock period wrong");

	property p_satisfied;
		upd && !oof_ff && st_ff == ST_STATUS && af_ff && policy == `POL_SAT
			|=> o_status_link_data == `WORD_SATISFIED;
	endproperty
	a_satisfied: assert property (p_satisfied) else $error("satisfied code not sent");

	property p_dip_to_frame;
		upd && !oof_ff && st_ff == ST_DIP |=> st_ff == ST_FRAME;
	endproperty
	a_dip_to_frame: assert property (p_dip_to_frame) else $error("framing word not after parity");

	c_in_frame: cover property (!oof_ff && st_ff == ST_STATUS);
	c_parity_word: cover property (upd && st_ff == ST_DIP && inject_ff);
	c_af_cycle: cover property (af_ff ##[1:50] !af_ff);
endmodule
`default_nettype wire

// ===== rtl/rx_status_params.svh
// constants and register map for the receive status calendar block
// How it works
// - strobe low stores channel at calendar index
// - strobe high reads channel at calendar index
// - status follows successive calendar entries
// - one word carries sixteen 2-bit statuses
// - bank n covers channels 16n to 16n+15
// - status updates only while strobe low
// - mask bit x gates channel 16n+x update
// - inject request inverts next parity word
// - consecutive DIP-4 errors drop frame, 0 as 1
// - consecutive training patterns gain frame, 0 as 1
// - calendar repeats setting plus one times
// - calendar length is setting plus one
// - almost-full sets at clamped on threshold
// - almost-full clears at clamped off threshold
// - link clock quarter or eighth rate
// - data changes on rising or falling edge
// - policy 00 drops frame, sends 11
// - policy 01 sends satisfied on all channels
// - policy 10/11 sends user status unchanged
// - out of frame while disabled or unsynced
`ifndef RX_STATUS_PARAMS_SVH
`define RX_STATUS_PARAMS_SVH
`define OFS_CTRL 12'h000
`define OFS_FRAME 12'h004
`define OFS_CAL 12'h008
`define OFS_AF 12'h00C
`define OFS_STATE 12'h010
`define CTRL_EN 0
`define CTRL_DIV 1
`define CTRL_EDGE 2
`define CTRL_POL_LO 3
`define CTRL_POL_HI 4
`define FRM_LOSS_LO 0
`define FRM_LOSS_HI 3
`define FRM_ACQ_LO 4
`define FRM_ACQ_HI 7
`define CAL_REP_LO 0
`define CAL_REP_HI 7
`define CAL_LEN_LO 16
`define CAL_LEN_HI 24
`define AF_ON_LO 0
`define AF_ON_HI 8
`define AF_OFF_LO 16
`define AF_OFF_HI 24
`define CTRL_RESET 5'h00
`define FRAME_RESET 8'h11
`define AF_ON_RESET 9'h010
`define AF_OFF_RESET 9'h020
`define AF_MIN 9'h001
`define AF_MAX 9'h1FC
`define POL_OOF 2'h0
`define POL_SAT 2'h1
`define WORD_FRAME 2'h3
`define WORD_SATISFIED 2'h2
`define HALF_DIV4 3'h2
`define HALF_DIV8 3'h4
`endif

// ===== rtl/rx_status_pkg.sv
// types shared by the receive status calendar block
package rx_status_pkg;
	typedef enum logic [1:0] {ST_OOF, ST_FRAME, ST_STATUS, ST_DIP} link_state_e;
	typedef logic [1:0] status_code_t;
endpackage

// ===== verif/link_rx_model.sv
// behavioural far-end receiver that samples the status link
`timescale 1ns/1ps
`default_nettype none
module link_rx_model
(
	input wire logic i_lclk,
	input wire logic [1:0] i_ldat,
	input wire logic i_edge,
	output logic o_stb,
	output logic [1:0] o_word
);
	initial o_stb = 1'b0;
	initial o_word = 2'h0;
	// sample on the edge away from the launch edge, mid-bit
	always @(i_lclk)
		if (i_lclk === i_edge)
		begin
			o_word = i_ldat;
			o_stb = ~o_stb;
		end
endmodule
`default_nettype wire

// ===== verif/rx_status_calendar_flow_ctrl_tb.sv
// self-checking bench for the receive status calendar block
`timescale 1ns/1ps
`default_nettype none
module rx_status_calendar_flow_ctrl_tb
	import rx_status_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0, prd, r;
	logic rdy, err, e, cal_n = 1'b1, st_n = 1'b1;
	logic [8:0] ci = 9'h000, free = 9'h100;
	logic [7:0] cw = 8'h00, cr;
	logic [31:0] sw = 32'h0;
	logic [3:0] sb = 4'h0;
	logic [15:0] sm = 16'h0;
	logic [3:0] ev = 4'h0;
	logic inj = 1'b0, lclk, af_n, oof, stb, edg = 1'b0;
	status_code_t ld, pw;
	bit [1:0] tab [256];
	bit [7:0] cal [3];
	status_code_t lq [$];
	logic [7:0] cq [$];
	int fail_count = 0, n_compared = 0;
	bit armed = 0, seen = 0, rd_go = 0, rd_seen = 0;
	logic [31:0] rv;

	always #50 clk = ~clk;

	rx_status_calendar_flow_ctrl dut_u (
		.i_ref_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd),
		.o_pready(rdy), .o_pslverr(err), .i_calendar_write_strobe_n(cal_n),
		.i_calendar_index(ci), .i_calendar_write_channel(cw),
		.o_calendar_read_channel(cr), .i_status_write_word(sw),
		.i_status_bank_select(sb), .i_status_write_strobe_n(st_n),
		.i_status_channel_mask(sm), .i_parity_error_inject_req(inj),
		.i_dip4_error(ev[2]), .i_dip4_ok(ev[3]), .i_train_pattern_done(ev[0]),
		.i_train_pattern_bad(ev[1]), .i_fifo_free_count(free),
		.o_status_link_clk(lclk), .o_status_link_data(ld),
		.o_rx_almost_full_n(af_n), .o_rx_out_of_frame(oof)
	);
	link_rx_model far_u (.i_lclk(lclk), .i_ldat(ld), .i_edge(edg), .o_stb(stb), .o_word(pw));

	task check(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task test_done;
		if (fail_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// one apb transfer, held until pready is seen at a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		r = prd;
		e = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	// receive-path events: bit0 training done, bit1 training bad, bit2 dip4 error, bit3 dip4 ok
	task pulse(input logic [3:0] s);
		@(posedge clk);
		ev <= s;
		@(posedge clk);
		ev <= 4'h0;
	endtask

	task wait_lvl(input logic sel, input logic v);
		for (int i = 0; i < 60 && (sel ? af_n : oof) !== v; i++)
			@(negedge clk);
		check(sel ? "almost_full_n" : "out_of_frame", 32'(sel ? af_n : oof), 32'(v));
	endtask

	task cal_op(input logic n, input int i, input logic [7:0] ch);
		@(posedge clk);
		cal_n <= n;
		ci <= 9'(i);
		cw <= ch;
		rd_go <= n;
		if (n)
			cq.push_back(cal[i]);
		else
			cal[i] = ch;
	endtask

	task st_op(input logic n, input logic [3:0] b, input logic [15:0] m, input logic [31:0] w);
		@(posedge clk);
		st_n <= n;
		sb <= b;
		sm <= m;
		sw <= w;
		for (int k = 0; k < 16; k++)
			if (!n && m[k])
				tab[{b, 4'(k)}] = w[2*k +: 2];
	endtask

	task per(input int n);
		realtime t;
		@(posedge lclk);
		t = $realtime;
		@(posedge lclk);
		check("link clock period", 32'(int'(($realtime - t) / 100.0)), 32'(n));
	endtask

	// disable, resync and note one full period; c is policy, edge, divide
	task run(input logic [3:0] c, input logic sat, input logic iv);
		bit [1:0] acc;
		bit [1:0] w;
		acc = 2'h0;
		apb(1'b1, 12'h000, {27'h0, c, 1'b0});
		wait_lvl(1'b0, 1'b1);
		edg = c[1];
		repeat (20) @(posedge clk);
		inj <= iv;
		@(posedge clk);
		inj <= 1'b0;
		for (int k = 0; k < 6; k++)
		begin
			w = sat ? 2'h2 : tab[cal[k % 3]];
			lq.push_back(w);
			acc = {acc[0], acc[1]} ^ w;
		end
		lq.push_back(iv ? ~acc : acc);
		lq.push_back(2'h3);
		seen = 0;
		armed = 1;
		apb(1'b1, 12'h000, {27'h0, c, 1'b1});
		pulse(4'h1);
		pulse(4'h2);
		pulse(4'h1);
		repeat (4) @(negedge clk);
		check("out_of_frame", 32'(oof), 32'h1);
		pulse(4'h1);
		wait_lvl(1'b0, 1'b0);
		for (int k = 0; k < 3000 && lq.size() > 0; k++)
			@(posedge clk);
		check("words left", 32'(lq.size()), 32'h0);
	endtask

	// far-end words are matched only after the frame words give way
	always @(stb)
		if (armed)
		begin
			if (pw !== 2'h3)
				seen = 1;
			if (seen && lq.size() > 0)
				check("link word", 32'(pw), 32'(lq.pop_front()));
			armed = lq.size() > 0;
		end

	always @(posedge clk)
	begin
		if (rd_seen)
			check("calendar read", 32'(cr), 32'(cq.pop_front()));
		rd_seen <= rd_go;
	end

	initial
	begin
		#(100 * 60000);
		fail_count++;
		test_done;
	end

	initial
	begin
		void'($urandom(97686));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, 12'h004, 32'h0);
		check("frame reg", r, 32'h0000_0011);
		apb(1'b0, 12'h00C, 32'h0);
		check("af reg", r, 32'h0020_0010);
		apb(1'b0, 12'h010, 32'h0);
		check("state reg", r, 32'h0000_0001);
		apb(1'b1, 12'h020, 32'hFFFF_FFFF);
		check("unmapped err", 32'(e), 32'h1);
		apb(1'b0, 12'h020, 32'h0);
		check("unmapped read", r, 32'h0);
		for (int k = 0; k < 3; k++)
			cal_op(1'b0, k, 8'($urandom));
		cal_op(1'b1, 2, 8'h00);
		cal_op(1'b1, 0, 8'h00);
		cal_op(1'b1, 1, 8'h00);
		@(posedge clk);
		rd_go <= 1'b0;
		for (int k = 0; k < 40; k++)
		begin
			rv = $urandom;
			st_op($urandom_range(0, 3) == 0, cal[k % 3][7:4], 16'($urandom),
				rv & ~((rv >> 1) & 32'h5555_5555));
		end
		@(posedge clk);
		st_n <= 1'b1;
		apb(1'b1, 12'h008, 32'h0002_0001);
		apb(1'b1, 12'h004, 32'h0000_0020);
		run(4'h8, 1'b0, 1'b0);
		run(4'hC, 1'b0, 1'b0);
		per(4);
		// two errors needed; a good parity between them restarts the count
		apb(1'b1, 12'h004, 32'h0000_0022);
		pulse(4'h4);
		pulse(4'h8);
		pulse(4'h4);
		repeat (4) @(negedge clk);
		check("out_of_frame", 32'(oof), 32'h0);
		pulse(4'h4);
		wait_lvl(1'b0, 1'b1);
		run(4'hB, 1'b0, 1'b1);
		per(8);
		apb(1'b1, 12'h00C, 32'h01FF_0000);
		@(posedge clk) free <= 9'h002;
		repeat (5) @(negedge clk);
		check("almost_full_n", 32'(af_n), 32'h1);
		@(posedge clk) free <= 9'h001;
		wait_lvl(1'b1, 1'b0);
		run(4'h4, 1'b1, 1'b0);
		@(posedge clk) free <= 9'h1FB;
		repeat (5) @(negedge clk);
		check("almost_full_n", 32'(af_n), 32'h0);
		@(posedge clk) free <= 9'h1FC;
		wait_lvl(1'b1, 1'b1);
		apb(1'b1, 12'h000, 32'h0000_0001);
		@(posedge clk) free <= 9'h001;
		wait_lvl(1'b0, 1'b1);
		repeat (3) @(stb);
		repeat (4) @(stb) check("link word", 32'(pw), 32'h3);
		@(posedge clk) free <= 9'h1FC;
		wait_lvl(1'b0, 1'b0);
		test_done;
	end
endmodule
`default_nettype wire
